//--- include/tpg_pkg.sv
// Purpose: shared constants and carriers for the test pattern generator
// Assumes: 100 MHz SYS_CLK, 12-bit pixel path, register port with one-cycle read data
// Notes: pattern codes follow the selector numbering
package tpg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIX_W = 12;
    localparam int COORD_W = 12;
    localparam int SEL_W = 3;
    localparam int CNT_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FRAME_CNT = 8'h08;

    // control field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_COLOR_BIT = 4;
    // status field positions
    localparam int STAT_SEL_LSB = 0;
    localparam int STAT_ACTIVE_BIT = 4;
    localparam int STAT_BYPASS_BIT = 5;
    localparam int STAT_COLOR_BIT = 6;

    localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h00000000;

    typedef enum logic [SEL_W-1:0] {
        pattern_select_none = 3'b000,
        pattern_select_fixed_gray8 = 3'b001,
        pattern_select_moving_gray8 = 3'b010,
        pattern_select_moving_gray12 = 3'b011,
        pattern_select_feature_gray8 = 3'b100,
        pattern_select_feature_gray12 = 3'b101,
        pattern_select_bayer_gb8 = 3'b110
    } pattern_select_e;

    // one pixel beat with frame and line markers
    typedef struct packed {
        logic valid;
        logic frame_start;
        logic line_start;
        logic [PIX_W-1:0] data;
    } pixel_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

//--- design/tpg_ramp.sv
// Purpose: diagonal ramp value from pixel coordinates and shift count
// Assumes: coordinates and shift from same clock domain
// Notes: purely combinational, narrow result sits in low 8 bits of a 12-bit word, wide result uses all 12
module tpg_ramp (
    input wire logic [tpg_pkg::COORD_W-1:0] x,
    input wire logic [tpg_pkg::COORD_W-1:0] y,
    input wire logic [tpg_pkg::CNT_W-1:0] shift,
    input wire logic wide,
    output logic [tpg_pkg::PIX_W-1:0] value
);
    logic [tpg_pkg::PIX_W-1:0] sum;

    // adding the shift moves the ramp one pixel right to left per step
    assign sum = x + y + shift[tpg_pkg::PIX_W-1:0];

    always_comb
    begin
        if (wide)
            value = sum;
        else
            value = {4'h0, sum[7:0]};
    end
endmodule

//--- design/test_pattern_generator.sv
// Purpose: replaces sensor pixels with synthetic diagonal test patterns
// Assumes: pixel stream and acquisition pulse are on SYS_CLK; color strap static
// Notes: five gray patterns plus a Bayer colour pattern on colour builds
module test_pattern_generator (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [tpg_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [tpg_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [tpg_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic COLOR_VARIANT,
    input wire logic ACQ_START,
    input wire tpg_pkg::pixel_s SENSOR_PIX,
    output tpg_pkg::pixel_s OUT_PIX,
    output logic DIGITAL_BYPASS,
    output logic ANALOG_OVERRIDE
);
    tpg_pkg::pattern_select_e sel_r;
    tpg_pkg::pattern_select_e sel_nxt;
    tpg_pkg::pattern_select_e frame_sel_r;
    logic color_sync_r;
    logic color_strap_r;
    logic [tpg_pkg::CNT_W-1:0] acq_cnt_r;
    logic [tpg_pkg::CNT_W-1:0] frame_shift_r;
    logic [tpg_pkg::COORD_W-1:0] x_r;
    logic [tpg_pkg::COORD_W-1:0] y_r;
    logic [tpg_pkg::COORD_W-1:0] x_cur;
    logic [tpg_pkg::COORD_W-1:0] y_cur;
    logic [tpg_pkg::CNT_W-1:0] shift_cur;
    logic wide_cur;
    logic [tpg_pkg::PIX_W-1:0] ramp_val;
    logic [tpg_pkg::PIX_W-1:0] green_val;
    logic [tpg_pkg::PIX_W-1:0] blue_val;
    logic [tpg_pkg::PIX_W-1:0] red_val;
    logic [tpg_pkg::PIX_W-1:0] bayer_val;
    logic [tpg_pkg::PIX_W-1:0] gen_val;
    logic active_cur;
    logic bypass_cur;
    logic [tpg_pkg::DATA_W-1:0] rdata_nxt;
    logic [tpg_pkg::DATA_W-1:0] rdata_r;
    tpg_pkg::pixel_s out_r;
    logic bypass_r;

    // strap is a pin: two flops before any logic reads it
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            color_sync_r <= 1'b0;
            color_strap_r <= 1'b0;
        end
        else
        begin
            color_sync_r <= COLOR_VARIANT;
            color_strap_r <= color_sync_r;
        end
    end

    // selector decode: illegal codes and colour pattern on mono fall back to none
    always_comb
    begin
        unique case (REG_WDATA[tpg_pkg::CTRL_SEL_LSB +: tpg_pkg::SEL_W])
            3'b000: sel_nxt = tpg_pkg::pattern_select_none;
            3'b001: sel_nxt = tpg_pkg::pattern_select_fixed_gray8;
            3'b010: sel_nxt = tpg_pkg::pattern_select_moving_gray8;
            3'b011: sel_nxt = tpg_pkg::pattern_select_moving_gray12;
            3'b100: sel_nxt = tpg_pkg::pattern_select_feature_gray8;
            3'b101: sel_nxt = tpg_pkg::pattern_select_feature_gray12;
            3'b110:
            begin
                if (color_strap_r)
                    sel_nxt = tpg_pkg::pattern_select_bayer_gb8;
                else
                    sel_nxt = tpg_pkg::pattern_select_none;
            end
            default: sel_nxt = tpg_pkg::pattern_select_none;
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            sel_r <= tpg_pkg::pattern_select_none;
        else if (REG_WR && REG_ADDR == tpg_pkg::OFS_CTRL)
            sel_r <= sel_nxt;
    end

    // acquisition counter; wraps freely, only low bits matter for the ramp
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            acq_cnt_r <= tpg_pkg::CNT_RESET;
        else if (ACQ_START)
            acq_cnt_r <= acq_cnt_r + 16'h0001;
    end

    // selection and shift are latched per frame so an image never tears
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            frame_sel_r <= tpg_pkg::pattern_select_none;
        else if (SENSOR_PIX.valid && SENSOR_PIX.frame_start)
            frame_sel_r <= sel_r;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            frame_shift_r <= tpg_pkg::CNT_RESET;
        else if (SENSOR_PIX.valid && SENSOR_PIX.frame_start)
            frame_shift_r <= acq_cnt_r;
    end

    // coordinates of the current pixel, taken from the stream markers
    always_comb
    begin
        if (SENSOR_PIX.frame_start)
        begin
            x_cur = 12'h000;
            y_cur = 12'h000;
        end
        else if (SENSOR_PIX.line_start)
        begin
            x_cur = 12'h000;
            y_cur = y_r + 12'h001;
        end
        else
        begin
            x_cur = x_r + 12'h001;
            y_cur = y_r;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            x_r <= 12'h000;
        else if (SENSOR_PIX.valid)
            x_r <= x_cur;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            y_r <= 12'h000;
        else if (SENSOR_PIX.valid)
            y_r <= y_cur;
    end

    // the first pixel of a frame must already use the new selection
    tpg_pkg::pattern_select_e use_sel;
    logic [tpg_pkg::CNT_W-1:0] use_shift;

    always_comb
    begin
        if (SENSOR_PIX.frame_start)
        begin
            use_sel = sel_r;
            use_shift = acq_cnt_r;
        end
        else
        begin
            use_sel = frame_sel_r;
            use_shift = frame_shift_r;
        end
    end

    always_comb
    begin
        shift_cur = use_shift;
        wide_cur = 1'b0;
        unique case (use_sel)
            tpg_pkg::pattern_select_fixed_gray8: shift_cur = tpg_pkg::CNT_RESET;
            tpg_pkg::pattern_select_moving_gray8: wide_cur = 1'b0;
            tpg_pkg::pattern_select_moving_gray12: wide_cur = 1'b1;
            tpg_pkg::pattern_select_feature_gray8: wide_cur = 1'b0;
            tpg_pkg::pattern_select_feature_gray12: wide_cur = 1'b1;
            tpg_pkg::pattern_select_bayer_gb8: shift_cur = tpg_pkg::CNT_RESET;
            tpg_pkg::pattern_select_none: wide_cur = 1'b0;
        endcase
    end

    // ramp built from coordinates and shift count, no sensor data involved
    tpg_ramp ramp_i (
        .x(x_cur),
        .y(y_cur),
        .shift(shift_cur),
        .wide(wide_cur),
        .value(ramp_val)
    );

    // bayer GB: even rows G B, odd rows R G; each channel ramps its own way
    // green follows the gray ramp, so a wrong mosaic phase shows as fringes
    assign green_val = {4'h0, ramp_val[7:0]};
    assign blue_val = {4'h0, x_cur[7:0]};
    assign red_val = {4'h0, y_cur[7:0]};

    always_comb
    begin
        unique case ({y_cur[0], x_cur[0]})
            2'b00: bayer_val = green_val;
            2'b01: bayer_val = blue_val;
            2'b10: bayer_val = red_val;
            2'b11: bayer_val = green_val;
        endcase
    end

    always_comb
    begin
        active_cur = (use_sel != tpg_pkg::pattern_select_none);
        bypass_cur = 1'b0;
        gen_val = ramp_val;
        unique case (use_sel)
            tpg_pkg::pattern_select_none: gen_val = SENSOR_PIX.data;
            tpg_pkg::pattern_select_fixed_gray8: bypass_cur = 1'b1;
            tpg_pkg::pattern_select_moving_gray8: bypass_cur = 1'b1;
            tpg_pkg::pattern_select_moving_gray12: bypass_cur = 1'b1;
            tpg_pkg::pattern_select_feature_gray8: bypass_cur = 1'b0;
            tpg_pkg::pattern_select_feature_gray12: bypass_cur = 1'b0;
            tpg_pkg::pattern_select_bayer_gb8:
            begin
                bypass_cur = 1'b1;
                gen_val = bayer_val;
            end
        endcase
    end

    // sensor data is discarded while a pattern runs, so analog settings vanish
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            out_r <= '0;
        else
        begin
            out_r.valid <= SENSOR_PIX.valid;
            out_r.frame_start <= SENSOR_PIX.frame_start;
            out_r.line_start <= SENSOR_PIX.line_start;
            out_r.data <= gen_val;
        end
    end

    // registered beside the pixel so downstream sees it on the same beat
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            bypass_r <= 1'b0;
        else
            bypass_r <= bypass_cur;
    end

    assign OUT_PIX = out_r;
    assign DIGITAL_BYPASS = bypass_r;
    assign ANALOG_OVERRIDE = (sel_r != tpg_pkg::pattern_select_none);

    // register read mux
    always_comb
    begin
        rdata_nxt = tpg_pkg::READ_UNMAPPED;
        unique case (REG_ADDR)
            tpg_pkg::OFS_CTRL:
            begin
                rdata_nxt[tpg_pkg::CTRL_SEL_LSB +: tpg_pkg::SEL_W] = sel_r;
                rdata_nxt[tpg_pkg::CTRL_COLOR_BIT] = color_strap_r;
            end
            // active bit reads the live pixel, so it may lead the stored selection
            tpg_pkg::OFS_STATUS:
            begin
                rdata_nxt[tpg_pkg::STAT_SEL_LSB +: tpg_pkg::SEL_W] = frame_sel_r;
                rdata_nxt[tpg_pkg::STAT_ACTIVE_BIT] = active_cur;
                rdata_nxt[tpg_pkg::STAT_BYPASS_BIT] = bypass_r;
                rdata_nxt[tpg_pkg::STAT_COLOR_BIT] = color_strap_r;
            end
            tpg_pkg::OFS_FRAME_CNT: rdata_nxt[tpg_pkg::CNT_W-1:0] = acq_cnt_r;
            default: rdata_nxt = tpg_pkg::READ_UNMAPPED;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            rdata_r <= tpg_pkg::READ_UNMAPPED;
        else if (REG_RD)
            rdata_r <= rdata_nxt;
        else
            rdata_r <= tpg_pkg::READ_UNMAPPED;
    end

    assign REG_RDATA = rdata_r;
endmodule

//--- sim/tpg_checker.sv
// Purpose: port-level checks of the pattern generator
// Assumes: colour strap static, selector written between frames
// Notes: sel_r mirrors the stored selector
module tpg_checker (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic COLOR_VARIANT,
    input wire logic ACQ_START,
    input wire tpg_pkg::pixel_s SENSOR_PIX,
    input wire tpg_pkg::pixel_s OUT_PIX,
    input wire logic DIGITAL_BYPASS,
    input wire logic ANALOG_OVERRIDE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    logic [1:0] color_r;
    logic [2:0] sel_r;
    logic [2:0] sel_nxt;
    logic [15:0] cnt_r;
    logic wr_ctrl;
    assign wr_ctrl = REG_WR && REG_ADDR == tpg_pkg::OFS_CTRL;
    // illegal codes fall back to no pattern
    // strap seen through the same two-flop delay as inside the block
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            color_r <= 2'h0;
        else
            color_r <= {color_r[0], COLOR_VARIANT};
    end
    assign sel_nxt = (REG_WDATA[2:0] == 3'h7 || (REG_WDATA[2:0] == 3'h6 && !color_r[1]))
        ? 3'h0 : REG_WDATA[2:0];
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            sel_r <= 3'h0;
        else if (wr_ctrl)
            sel_r <= sel_nxt;
    end
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
            cnt_r <= 16'h0000;
        else if (ACQ_START)
            cnt_r <= cnt_r + 16'h0001;
    end
    sequence frame_in;
        SENSOR_PIX.valid && SENSOR_PIX.frame_start;
    endsequence
    valid_follow_a: assert property (SENSOR_PIX.valid |=> OUT_PIX.valid)
        else $error("output valid missing");
    frame_mark_a: assert property (frame_in |=> OUT_PIX.frame_start)
        else $error("frame marker lost");
    line_mark_a: assert property (SENSOR_PIX.line_start |=> OUT_PIX.line_start)
        else $error("line marker lost");
    rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 32'h00000000)
        else $error("read data without read");
    pass_thru_a: assert property (SENSOR_PIX.valid && !ANALOG_OVERRIDE
        |=> OUT_PIX.data == $past(SENSOR_PIX.data)) else $error("sensor data altered");
    bypass_code_a: assert property (frame_in
        |=> DIGITAL_BYPASS == ($past(sel_r) inside {3'h1, 3'h2, 3'h3, 3'h6}))
        else $error("bypass wrong for pattern");
    override_sel_a: assert property (wr_ctrl |=> ANALOG_OVERRIDE == (sel_r != 3'h0))
        else $error("analog override wrong");
    count_read_a: assert property (REG_RD && REG_ADDR == tpg_pkg::OFS_FRAME_CNT
        |=> REG_RDATA[15:0] == $past(cnt_r)) else $error("acquisition count wrong");
endmodule

//--- sim/tpg_pipe_model.sv
// Purpose: downstream pixel pipeline with a lookup stage
// Assumes: lookup modelled as bit inversion
// Notes: combinational, so it lines up with OUT_PIX
module tpg_pipe_model (
    input wire tpg_pkg::pixel_s pix,
    input wire logic bypass,
    input wire logic lut_en,
    output logic [11:0] out_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // skipped for patterns that must not show processing
    assign out_data = (bypass || !lut_en) ? pix.data : ~pix.data;
endmodule

//--- sim/test_pattern_generator_tb_top.sv
// Purpose: self-checking bench for the pattern generator
// Assumes: colour build strap, 4x3 frames
// Notes: selector changed only between frames
module test_pattern_generator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h00000000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic COLOR_VARIANT = 1'b1;
    logic ACQ_START = 1'b0;
    logic lut_en = 1'b1;
    tpg_pkg::pixel_s SENSOR_PIX = '0;
    tpg_pkg::pixel_s OUT_PIX;
    logic DIGITAL_BYPASS;
    logic ANALOG_OVERRIDE;
    logic [11:0] proc_data;
    int error_cnt = 0;
    int total_checks = 0;
    int acq = 0;
    always #5 SYS_CLK = ~SYS_CLK;
    test_pattern_generator u_dut (
        .SYS_CLK(SYS_CLK),
        .RESET_N(RESET_N),
        .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR),
        .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA),
        .COLOR_VARIANT(COLOR_VARIANT),
        .ACQ_START(ACQ_START),
        .SENSOR_PIX(SENSOR_PIX),
        .OUT_PIX(OUT_PIX),
        .DIGITAL_BYPASS(DIGITAL_BYPASS),
        .ANALOG_OVERRIDE(ANALOG_OVERRIDE)
    );
    tpg_pipe_model u_pipe (.pix(OUT_PIX), .bypass(DIGITAL_BYPASS), .lut_en(lut_en),
        .out_data(proc_data));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1;
        check(what, exp, REG_RDATA);
    endtask
    function automatic logic [11:0] expv(logic [2:0] sel, logic [11:0] x, logic [11:0] y,
        logic [11:0] s, logic [11:0] d);
        case (sel)
            3'h1: return (x + y) & 12'h0FF;
            3'h2, 3'h4: return (x + y + s) & 12'h0FF;
            3'h3, 3'h5: return x + y + s;
            3'h6: return (x[0] == y[0]) ? ((x + y) & 12'h0FF) : (y[0] ? y : x);
            default: return d;
        endcase
    endfunction
    task automatic frame(input logic [2:0] sel);
        logic [11:0] e;
        logic byp;
        int j;
        byp = sel inside {3'h1, 3'h2, 3'h3, 3'h6};
        @(posedge SYS_CLK);
        ACQ_START <= 1'b1;
        @(posedge SYS_CLK);
        ACQ_START <= 1'b0;
        acq++;
        for (int i = 0; i <= 12; i++)
        begin
            @(posedge SYS_CLK);
            SENSOR_PIX <= (i < 12) ? {1'b1, i == 0, i % 4 == 0 && i > 0, 12'hA00 + 12'(i)} : '0;
            #1;
            j = i - 1;
            if (i > 0)
            begin
                e = expv(sel, 12'(j % 4), 12'(j / 4), 12'(acq), 12'hA00 + 12'(j));
                check("pix", {20'h0, e}, {20'h0, OUT_PIX.data});
                check("bypass", {31'h0, byp}, {31'h0, DIGITAL_BYPASS});
                check("lut", {20'h0, byp ? e : ~e}, {20'h0, proc_data});
            end
        end
    endtask
    task automatic t_regs();
        rd("cnt", tpg_pkg::OFS_FRAME_CNT, 32'h00000000);
        rd("unmapped", 8'h0C, 32'h00000000);
        rd("ctrl", tpg_pkg::OFS_CTRL, 32'h00000010);
        $display("regs done");
    endtask
    task automatic t_mono();
        @(posedge SYS_CLK);
        COLOR_VARIANT <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        wr(tpg_pkg::OFS_CTRL, 32'h00000006);
        #1;
        check("mono override", 32'h00000000, {31'h0, ANALOG_OVERRIDE});
        rd("mono ctrl", tpg_pkg::OFS_CTRL, 32'h00000000);
        @(posedge SYS_CLK);
        COLOR_VARIANT <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        $display("mono done");
    endtask
    task automatic t_count();
        @(posedge SYS_CLK);
        ACQ_START <= 1'b1;
        repeat (253) @(posedge SYS_CLK);
        ACQ_START <= 1'b0;
        acq = 253;
        rd("cnt", tpg_pkg::OFS_FRAME_CNT, 32'h000000FD);
        $display("count done");
    endtask
    task automatic t_patterns();
        logic [2:0] eff;
        logic byp;
        for (int k = 0; k < 8; k++)
        begin
            eff = (k == 7) ? 3'h0 : 3'(k);
            byp = eff inside {3'h1, 3'h2, 3'h3, 3'h6};
            wr(tpg_pkg::OFS_CTRL, 32'(k));
            #1;
            check("override", {31'h0, eff != 3'h0}, {31'h0, ANALOG_OVERRIDE});
            rd("ctrl", tpg_pkg::OFS_CTRL, {27'h0, 1'b1, 1'b0, eff});
            frame(eff);
            rd("status", tpg_pkg::OFS_STATUS, {25'h0, 1'b1, byp, eff != 3'h0, 1'b0, eff});
        end
        $display("patterns done");
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        t_regs();
        t_count();
        t_mono();
        t_patterns();
        complete_run();
    end
    initial
    begin
        repeat (5000) @(posedge SYS_CLK);
        error_cnt++;
        complete_run();
    end
endmodule
bind test_pattern_generator tpg_checker u_chk (
    .SYS_CLK(SYS_CLK),
    .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .COLOR_VARIANT(COLOR_VARIANT),
    .ACQ_START(ACQ_START),
    .SENSOR_PIX(SENSOR_PIX),
    .OUT_PIX(OUT_PIX),
    .DIGITAL_BYPASS(DIGITAL_BYPASS),
    .ANALOG_OVERRIDE(ANALOG_OVERRIDE)
);
